// >>> core/ext_port_pkg.sv
// Shared constants, types and helpers for the external memory port sequencer.
package ext_port_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 24;
  localparam int WAIT_W = 4;
  localparam int SPACES = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int SPACE_W = 2;
  localparam int RD_WORD_W = SPACE_W + ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // Space indices, also bit positions in a request mask
  // ----------------------------------------------------------------
  localparam logic [SPACE_W-1:0] SPACE_X = 2'h0;
  localparam logic [SPACE_W-1:0] SPACE_Y = 2'h1;
  localparam logic [SPACE_W-1:0] SPACE_P = 2'h2;

  // ----------------------------------------------------------------
  // Select encodings, ordered {program_n, data_n, x_not_y}
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_IDLE = 3'h7;
  localparam logic [2:0] SEL_X = 3'h5;
  localparam logic [2:0] SEL_Y = 3'h4;
  localparam logic [2:0] SEL_P = 3'h3;
  localparam logic [2:0] SEL_VEC = 3'h2;
  localparam logic [2:0] SEL_RSVD = 3'h6;
  localparam logic [1:0] SEL_BOTH_LOW = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASES_PER_ICYC = 4;
  localparam int TW_PER_WAIT = 2;
  localparam logic [WAIT_W:0] WCNT_ONE = 5'h01;

  typedef enum logic [2:0] {st_idle, st_t0, st_t1, st_t2, st_tw, st_t3} bus_state_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fixed order: X first, then Y, then program.
  function automatic logic [SPACE_W-1:0] pick_space(input logic [SPACES-1:0] m);
    logic [SPACE_W-1:0] s;
    s = SPACE_P;
    if (m[SPACE_Y]) begin
      s = SPACE_Y;
    end
    if (m[SPACE_X]) begin
      s = SPACE_X;
    end
    return s;
  endfunction

  // Vector encoding is only produced in development mode.
  function automatic logic [2:0] sel_code(input logic [SPACE_W-1:0] s, input logic vec,
                                          input logic dev);
    logic [2:0] c;
    c = SEL_P;
    if (s == SPACE_X) begin
      c = SEL_X;
    end else if (s == SPACE_Y) begin
      c = SEL_Y;
    end else if (vec && dev) begin
      c = SEL_VEC;
    end
    return c;
  endfunction

endpackage

// >>> core/external_memory_port_sequencer.sv
// External memory port sequencer: serialises X, Y and program references onto one bus.
// Behaviour
// (RULE_01) One external access per instruction cycle.
// (RULE_02) Several accesses go X, then Y, then program.
// (RULE_03) XY or long references become two accesses.
// (RULE_04) Sixteen-bit address, one access per cycle.
// (RULE_05) Space selects act as extra address bits.
// (RULE_06) Strobes exclusive, with guard gap between them.
// (RULE_07) Development-mode vector fetch drives x_not_y low.
// (RULE_08) Data reference: program high, data low, X/Y.
// (RULE_09) Idle all high; program fetch program low.
// (RULE_10) Vector fetch encoding is program low, x_not_y low.
// (RULE_11) Internal-only work leaves external pins still.
// (RULE_12) Memory may use strobes as direction/enable.
// (RULE_13) Program select may serve as chip select.
// (RULE_14) Address and selects change in first phase.
// (RULE_15) Strobe asserts second phase, negates fourth.
// (RULE_16) Wait count adds phases, delays write strobe.
// (RULE_17) Address and selects hold until next cycle.
// (RULE_18) Reserved select combinations are never driven.
// (RULE_19) Data pins input on read, driven on write.
module external_memory_port_sequencer
  import ext_port_pkg::*;
#(
  parameter int FIFO_WORDS = ext_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                              i_mclk,
  input  wire logic                              i_rst_n,
  // Configuration
  input  wire logic                              i_dev_mode,
  input  wire logic [ext_port_pkg::WAIT_W-1:0]   i_wait_x,
  input  wire logic [ext_port_pkg::WAIT_W-1:0]   i_wait_y,
  input  wire logic [ext_port_pkg::WAIT_W-1:0]   i_wait_p,
  // Instruction request
  input  wire logic                              i_cmd_valid,
  output logic                                   o_cmd_ready,
  input  wire logic                              i_cmd_x_en,
  input  wire logic                              i_cmd_y_en,
  input  wire logic                              i_cmd_p_en,
  input  wire logic                              i_cmd_x_wr,
  input  wire logic                              i_cmd_y_wr,
  input  wire logic                              i_cmd_p_wr,
  input  wire logic                              i_cmd_p_vector,
  input  wire logic [ext_port_pkg::ADDR_W-1:0]   i_cmd_x_addr,
  input  wire logic [ext_port_pkg::ADDR_W-1:0]   i_cmd_y_addr,
  input  wire logic [ext_port_pkg::ADDR_W-1:0]   i_cmd_p_addr,
  input  wire logic [ext_port_pkg::DATA_W-1:0]   i_cmd_x_wdata,
  input  wire logic [ext_port_pkg::DATA_W-1:0]   i_cmd_y_wdata,
  input  wire logic [ext_port_pkg::DATA_W-1:0]   i_cmd_p_wdata,
  // Read return
  output logic                                   o_rd_valid,
  input  wire logic                              i_rd_ready,
  output logic [ext_port_pkg::SPACE_W-1:0]       o_rd_space,
  output logic [ext_port_pkg::ADDR_W-1:0]        o_rd_addr,
  output logic [ext_port_pkg::DATA_W-1:0]        o_rd_data,
  // External bus
  output logic [ext_port_pkg::ADDR_W-1:0]        o_ext_address,
  output logic                                   o_program_space_select_n,
  output logic                                   o_data_space_select_n,
  output logic                                   o_x_not_y_select,
  output logic                                   o_read_strobe_n,
  output logic                                   o_write_strobe_n,
  output logic [ext_port_pkg::DATA_W-1:0]        o_ext_data,
  output logic                                   o_ext_data_oe,
  input  wire logic [ext_port_pkg::DATA_W-1:0]   i_ext_data
);
  import ext_port_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_e state_q, state_d;
  logic [SPACES-1:0] pend_q, pend_d, wr_q, wr_d;
  logic vec_q, vec_d, rdy_q, rdy_d;
  logic [SPACES-1:0][ADDR_W-1:0] addr_q, addr_d, in_addr, eff_addr;
  logic [SPACES-1:0][DATA_W-1:0] wdat_q, wdat_d, in_wdat, eff_wdat;
  logic [SPACES-1:0] in_mask, in_wr, eff_mask, eff_wr;
  logic eff_vec;
  logic [ADDR_W-1:0] ext_addr_q, ext_addr_d;
  logic [2:0] sel_q, sel_d;
  logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic [SPACE_W-1:0] cur_sp_q, cur_sp_d, sp;
  logic cur_wr_q, cur_wr_d;
  logic [WAIT_W-1:0] cur_wait_q, cur_wait_d;
  logic [WAIT_W:0] wcnt_q, wcnt_d;
  logic accept, go, push, fifo_rdy, can_start;
  logic [RD_WORD_W-1:0] fifo_out;

  assign in_mask = {i_cmd_p_en, i_cmd_y_en, i_cmd_x_en};
  assign in_wr = {i_cmd_p_wr, i_cmd_y_wr, i_cmd_x_wr};
  assign in_addr = {i_cmd_p_addr, i_cmd_y_addr, i_cmd_x_addr};
  assign in_wdat = {i_cmd_p_wdata, i_cmd_y_wdata, i_cmd_x_wdata};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    wr_d = wr_q;
    vec_d = vec_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    ext_addr_d = ext_addr_q;
    sel_d = sel_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    oe_d = oe_q;
    dout_d = dout_q;
    cur_sp_d = cur_sp_q;
    cur_wr_d = cur_wr_q;
    cur_wait_d = cur_wait_q;
    wcnt_d = wcnt_q;
    push = 1'b0;
    accept = rdy_q && i_cmd_valid;
    eff_mask = accept ? in_mask : pend_q;
    eff_wr = accept ? in_wr : wr_q;
    eff_addr = accept ? in_addr : addr_q;
    eff_wdat = accept ? in_wdat : wdat_q;
    eff_vec = accept ? i_cmd_p_vector : vec_q;
    if (accept) begin
      pend_d = in_mask;
      wr_d = in_wr;
      addr_d = in_addr;
      wdat_d = in_wdat;
      vec_d = i_cmd_p_vector;
    end
    sp = pick_space(eff_mask); // see RULE_02, RULE_03
    can_start = (state_q == st_idle) || (state_q == st_t3);
    // A read waits in idle until the return FIFO has room, so no word is ever dropped.
    go = can_start && (eff_mask != '0) && (eff_wr[sp] || fifo_rdy);
    unique case (state_q)
      st_idle: begin
      end
      st_t0: begin
        state_d = st_t1;
        if (!cur_wr_q) begin
          rd_n_d = 1'b0; // see RULE_15, RULE_19
        end else if (cur_wait_q == '0) begin
          wr_n_d = 1'b0; // see RULE_15
          oe_d = 1'b1; // see RULE_19
        end
      end
      st_t1: begin
        state_d = st_t2;
        if (cur_wr_q && (cur_wait_q != '0)) begin
          wr_n_d = 1'b0; // see RULE_16
          oe_d = 1'b1; // see RULE_19
        end
      end
      st_t2, st_tw: begin
        if ((state_q == st_t2) && (cur_wait_q != '0)) begin
          state_d = st_tw;
          wcnt_d = {cur_wait_q, 1'b0} - WCNT_ONE; // see RULE_16
        end else if ((state_q == st_tw) && (wcnt_q != '0)) begin
          wcnt_d = wcnt_q - WCNT_ONE;
        end else begin
          state_d = st_t3;
          rd_n_d = 1'b1; // see RULE_15
          wr_n_d = 1'b1;
          push = !cur_wr_q; // see RULE_15
        end
      end
      st_t3: begin
        state_d = st_idle;
        oe_d = 1'b0; // see RULE_19
        sel_d = SEL_IDLE; // see RULE_09, RULE_14
      end
    endcase
    if (go) begin
      // Only the selected space's address, and for a write its data, are loaded; the rest stay put.
      state_d = st_t0; // see RULE_01, RULE_04
      pend_d = eff_mask & ~(SPACES'(1) << sp);
      ext_addr_d = eff_addr[sp]; // see RULE_14, RULE_17
      sel_d = sel_code(sp, eff_vec, i_dev_mode); // see RULE_05, RULE_07, RULE_08, RULE_10, RULE_18
      cur_sp_d = sp;
      cur_wr_d = eff_wr[sp];
      oe_d = 1'b0;
      if (eff_wr[sp]) begin
        dout_d = eff_wdat[sp]; // see RULE_11
      end
      cur_wait_d = (sp == SPACE_X) ? i_wait_x : (sp == SPACE_Y) ? i_wait_y : i_wait_p;
    end
    rdy_d = (pend_d == '0) && ((state_d == st_idle) || (state_d == st_t3));
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= st_idle;
      pend_q <= '0;
      wr_q <= '0;
      vec_q <= 1'b0;
      addr_q <= '0;
      wdat_q <= '0;
      ext_addr_q <= '0;
      sel_q <= SEL_IDLE;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_q <= 1'b0;
      dout_q <= '0;
      cur_sp_q <= SPACE_X;
      cur_wr_q <= 1'b0;
      cur_wait_q <= '0;
      wcnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      wr_q <= wr_d;
      vec_q <= vec_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      ext_addr_q <= ext_addr_d;
      sel_q <= sel_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      cur_sp_q <= cur_sp_d;
      cur_wr_q <= cur_wr_d;
      cur_wait_q <= cur_wait_d;
      wcnt_q <= wcnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign o_cmd_ready = rdy_q;
  assign o_ext_address = ext_addr_q;
  assign {o_program_space_select_n, o_data_space_select_n, o_x_not_y_select} = sel_q;
  assign o_read_strobe_n = rd_n_q;
  assign o_write_strobe_n = wr_n_q;
  assign o_ext_data = dout_q;
  assign o_ext_data_oe = oe_q;

  // ----------------------------------------------------------------
  // Read return buffer
  // ----------------------------------------------------------------
  stream_fifo #(.WIDTH(RD_WORD_W), .DEPTH(FIFO_WORDS)) u_rd_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_valid (push),
    .o_ready (fifo_rdy),
    .i_data  ({cur_sp_q, ext_addr_q, i_ext_data}),
    .o_valid (o_rd_valid),
    .i_ready (i_rd_ready),
    .o_data  (fifo_out)
  );
  assign {o_rd_space, o_rd_addr, o_rd_data} = fifo_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_strobe_two_phases(logic s);
    !s ##1 !s ##1 s;
  endsequence

  AST_STROBE_EXCL: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_06
    o_read_strobe_n || o_write_strobe_n) else $error("read and write strobes both low");
  AST_GUARD_GAP: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_06
    ($fell(o_read_strobe_n) || $fell(o_write_strobe_n)) |->
      $past(o_read_strobe_n) && $past(o_write_strobe_n) && $past(o_read_strobe_n, 2)
      && $past(o_write_strobe_n, 2)) else $error("no strobe guard gap");
  AST_NO_RESERVED: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_18
    (sel_q != SEL_RSVD) && (sel_q[2:1] != SEL_BOTH_LOW)) else $error("reserved select code");
  AST_VEC_ONLY_DEV: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_10
    (state_q == st_t0) && (sel_q == SEL_VEC) |-> cur_sp_q == SPACE_P && $past(i_dev_mode))
    else $error("vector select outside development mode");
  AST_IDLE_SEL: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_09
    (state_q == st_idle) |-> (sel_q == SEL_IDLE) && o_read_strobe_n && o_write_strobe_n
      && !o_ext_data_oe) else $error("idle bus not quiet");
  AST_ONE_PER_ICYC: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_01
    (state_q == st_t0) |=> (state_q != st_t0) [*3]) else $error("access shorter than cycle");
  AST_XY_ORDER: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_02
    (state_q == st_t0) && (cur_sp_q != SPACE_X) |-> !pend_q[SPACE_X])
    else $error("X reference left behind");
  AST_ZW_STROBE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_15
    (state_q == st_t0) && (cur_wait_q == '0) && !cur_wr_q |=>
      s_strobe_two_phases(o_read_strobe_n)) else $error("zero-wait read strobe timing");
  AST_WR_DELAY: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_16
    (state_q == st_t1) && cur_wr_q && (cur_wait_q != '0) |-> o_write_strobe_n ##1
      !o_write_strobe_n) else $error("delayed write strobe misplaced");
  AST_ADDR_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_17
    $changed(o_ext_address) |-> (state_q == st_t0)) else $error("address moved outside T0");
  AST_READ_NO_DRIVE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_19
    !o_read_strobe_n |-> !o_ext_data_oe) else $error("data driven during read");
endmodule

// >>> core/stream_fifo.sv
// Synchronous valid/ready FIFO with registered flags and registered head word.
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q, mem_d;
  logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, vld_q, vld_d;
  logic [WIDTH-1:0] head_q, head_d;
  logic wr, rd;

  assign o_ready = rdy_q;
  assign o_valid = vld_q;
  assign o_data = head_q;

  always_comb begin
    wr = i_valid && rdy_q;
    rd = i_ready && vld_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (wr) begin
      mem_d[wp_q] = i_data;
      wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
    end
    if (rd) begin
      rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
    end
    if (wr && !rd) begin
      cnt_d = cnt_q + 1'b1;
    end else if (rd && !wr) begin
      cnt_d = cnt_q - 1'b1;
    end
    rdy_d = (cnt_d != FULL);
    vld_d = (cnt_d != '0);
    head_d = mem_d[rp_d];
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
      head_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      head_q <= head_d;
    end
  end
endmodule

// >>> verification/ext_memory_model.sv
// Behavioural static memory with three spaces on the far side of the external port.
module ext_memory_model
  import ext_port_pkg::*;
(
  // Clock
  input  wire logic                            i_mclk,
  // Bus from the port
  input  wire logic [ext_port_pkg::ADDR_W-1:0] i_address,
  input  wire logic                            i_ps_n,
  input  wire logic                            i_ds_n,
  input  wire logic                            i_xy,
  input  wire logic                            i_rd_n,
  input  wire logic                            i_wr_n,
  input  wire logic [ext_port_pkg::DATA_W-1:0] i_wdata,
  // Data driven back
  output logic [ext_port_pkg::DATA_W-1:0]      o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [logic [17:0]];
  logic [17:0] key;
  logic wr_n_q = 1'b1;

  function automatic logic [DATA_W-1:0] dflt(input logic [17:0] k);
    return {k[5:0], k} ^ 24'ha5_5a5a;
  endfunction

  initial o_rdata = 24'h00_0000;
  // Program select alone enables program memory; the selects act as address bits.
  assign key = {(i_ps_n ? {1'b0, ~i_xy} : 2'h2), i_address};

  always @(posedge i_mclk) begin
    wr_n_q <= i_wr_n;
    // Read line used as output enable; a released bus never keeps its last value.
    if (!i_rd_n && !(i_ps_n && i_ds_n)) begin
      o_rdata <= mem.exists(key) ? mem[key] : dflt(key);
    end else begin
      o_rdata <= ~o_rdata;
    end
    // Write line used as direction control; data is taken as it negates.
    if (!wr_n_q && i_wr_n) begin
      mem[key] = i_wdata;
    end
  end
endmodule

// >>> verification/external_memory_port_sequencer_tb_top.sv
// Self-checking random testbench of the external memory port sequencer.
module external_memory_port_sequencer_tb_top import ext_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] sp; logic [15:0] a; logic wr; logic [23:0] d; int w;
                  logic [2:0] sel;} acc_s;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_dev_mode = 1'b0, i_cmd_valid = 1'b0;
  logic [3:0] i_wait_x = 4'h0, i_wait_y = 4'h0, i_wait_p = 4'h0;
  logic i_cmd_x_en = 1'b0, i_cmd_y_en = 1'b0, i_cmd_p_en = 1'b0, i_cmd_p_vector = 1'b0;
  logic i_cmd_x_wr = 1'b0, i_cmd_y_wr = 1'b0, i_cmd_p_wr = 1'b0, i_rd_ready = 1'b0;
  logic [15:0] i_cmd_x_addr = 16'h0000, i_cmd_y_addr = 16'h0000, i_cmd_p_addr = 16'h0000;
  logic [23:0] i_cmd_x_wdata = 24'h00_0000, i_cmd_y_wdata = 24'h00_0000;
  logic [23:0] i_cmd_p_wdata = 24'h00_0000, i_ext_data, o_rd_data, o_ext_data;
  logic o_cmd_ready, o_rd_valid, o_program_space_select_n, o_data_space_select_n;
  logic o_x_not_y_select, o_read_strobe_n, o_write_strobe_n, o_ext_data_oe;
  logic [1:0] o_rd_space;
  logic [15:0] o_rd_addr, o_ext_address, a_p, last_a;
  logic [2:0] sel;
  logic [23:0] bmem [logic [17:0]];
  acc_s acc_q[$], rd_q[$], cur, e;
  int falls[$];
  int num_errors = 0, checks_done = 0, cyc = 0, lowcnt = 0, hicnt = 8;
  logic stall = 1'b0, rd_p = 1'b1, wr_p = 1'b1;

  always #5 i_mclk = ~i_mclk;

  external_memory_port_sequencer #(.FIFO_WORDS(8)) DUT (.i_mclk, .i_rst_n, .i_dev_mode,
    .i_wait_x, .i_wait_y, .i_wait_p, .i_cmd_valid, .o_cmd_ready, .i_cmd_x_en, .i_cmd_y_en,
    .i_cmd_p_en, .i_cmd_x_wr, .i_cmd_y_wr, .i_cmd_p_wr, .i_cmd_p_vector, .i_cmd_x_addr,
    .i_cmd_y_addr, .i_cmd_p_addr, .i_cmd_x_wdata, .i_cmd_y_wdata, .i_cmd_p_wdata,
    .o_rd_valid, .i_rd_ready, .o_rd_space, .o_rd_addr, .o_rd_data, .o_ext_address,
    .o_program_space_select_n, .o_data_space_select_n, .o_x_not_y_select,
    .o_read_strobe_n, .o_write_strobe_n, .o_ext_data, .o_ext_data_oe, .i_ext_data);

  ext_memory_model mem_model (.i_mclk(i_mclk), .i_address(o_ext_address),
    .i_ps_n(o_program_space_select_n), .i_ds_n(o_data_space_select_n),
    .i_xy(o_x_not_y_select), .i_rd_n(o_read_strobe_n), .i_wr_n(o_write_strobe_n),
    .i_wdata(o_ext_data), .o_rdata(i_ext_data));

  // ----------------------------------------------------------------
  // Expectations and reporting
  // ----------------------------------------------------------------
  function automatic logic [23:0] exp_dflt(input logic [17:0] k);
    return {k[5:0], k} ^ 24'ha5_5a5a;
  endfunction

  function automatic logic [2:0] exp_sel(input logic [1:0] sp, input logic vec, input logic dv);
    if (sp == 2'h0) return 3'h5;
    if (sp == 2'h1) return 3'h4;
    return (vec && dv) ? 3'h2 : 3'h3;
  endfunction

  // Phases a strobe stays low: delayed writes lose one phase, reads never do.
  function automatic int exp_low(input logic wr, input int w);
    if (wr) return (w == 0) ? 2 : 1 + 2 * w;
    return 2 + 2 * w;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Waits are only changed while nothing is pending, since they are sampled at load.
  task automatic send(input logic [2:0] m, input logic [2:0] wr, input logic vec, input int wm);
    logic [15:0] ad [3];
    logic [23:0] dt [3];
    int w [3];
    logic dv;
    int n;
    n = 0;
    @(posedge i_mclk);
    while (o_cmd_ready !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    dv = 1'($urandom % 2);
    for (int i = 0; i < 3; i++) begin
      ad[i] = 16'($urandom % 8);
      dt[i] = 24'($urandom);
      w[i] = $urandom % (wm + 1);
    end
    {i_cmd_x_en, i_cmd_y_en, i_cmd_p_en} <= {m[0], m[1], m[2]};
    {i_cmd_x_wr, i_cmd_y_wr, i_cmd_p_wr} <= {wr[0], wr[1], wr[2]};
    {i_cmd_x_addr, i_cmd_y_addr, i_cmd_p_addr} <= {ad[0], ad[1], ad[2]};
    {i_cmd_x_wdata, i_cmd_y_wdata, i_cmd_p_wdata} <= {dt[0], dt[1], dt[2]};
    {i_wait_x, i_wait_y, i_wait_p} <= {4'(w[0]), 4'(w[1]), 4'(w[2])};
    i_dev_mode <= dv;
    i_cmd_p_vector <= vec;
    i_cmd_valid <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_cmd_ready !== 1'b1 && n < 600);
    i_cmd_valid <= 1'b0;
    check(o_cmd_ready, 1'b1);
    for (int i = 0; i < 3; i++) begin
      if (m[i]) begin
        e = '{2'(i), ad[i], wr[i], dt[i], w[i], exp_sel(2'(i), vec, dv)};
        if (!wr[i]) begin
          e.d = bmem.exists({e.sp, e.a}) ? bmem[{e.sp, e.a}] : exp_dflt({e.sp, e.a});
          rd_q.push_back(e);
        end else begin
          bmem[{e.sp, e.a}] = dt[i];
        end
        acc_q.push_back(e);
      end
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((acc_q.size() != 0 || rd_q.size() != 0) && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    check(n < 3000, 1'b1);
    repeat (12) @(posedge i_mclk);
  endtask

  always @(posedge i_mclk) i_rd_ready <= stall ? 1'b0 : ($urandom % 4 != 0);

  // ----------------------------------------------------------------
  // Bus and return monitor
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    cyc++;
    sel = {o_program_space_select_n, o_data_space_select_n, o_x_not_y_select};
    if (i_rst_n) begin
      check(o_read_strobe_n | o_write_strobe_n, 1'b1);
      check(sel[2:1] != 2'h0 && sel != 3'h6, 1'b1);
      if (o_ext_address !== a_p) check(sel != 3'h7, 1'b1);
      if ((!o_read_strobe_n && rd_p) || (!o_write_strobe_n && wr_p)) begin
        check(hicnt >= 2, 1'b1);
        falls.push_back(cyc);
        check(acc_q.size() != 0, 1'b1);
        cur = acc_q.pop_front();
        last_a = cur.a;
        check(sel, cur.sel);
        check(o_ext_address, cur.a);
        check({!o_write_strobe_n, o_ext_data_oe}, {cur.wr, cur.wr});
        if (cur.wr) check(o_ext_data, cur.d);
        lowcnt = 0;
      end
      if (!o_read_strobe_n || !o_write_strobe_n) begin
        lowcnt++;
        hicnt = 0;
      end else begin
        hicnt++;
      end
      if ((o_read_strobe_n && !rd_p) || (o_write_strobe_n && !wr_p))
        check(lowcnt, exp_low(cur.wr, cur.w));
      if (o_rd_valid === 1'b1 && i_rd_ready) begin
        check(rd_q.size() != 0, 1'b1);
        e = rd_q.pop_front();
        check({o_rd_space, o_rd_addr, o_rd_data}, {e.sp, e.a, e.d});
      end
    end
    {rd_p, wr_p, a_p} = {o_read_strobe_n, o_write_strobe_n, o_ext_address};
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hfcd5));
    repeat (10) @(posedge i_mclk);
    check({sel, o_read_strobe_n, o_write_strobe_n, o_ext_data_oe}, 6'h3e);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    falls.delete();
    send(3'h7, 3'h0, 1'b0, 0);
    wait_idle();
    check(falls[1] - falls[0], 4);
    check(falls[2] - falls[1], 4);
    repeat (250) send(3'($urandom), 3'($urandom), 1'($urandom), 3);
    wait_idle();
    stall <= 1'b1;
    repeat (9) send(3'h1, 3'h0, 1'b0, 0);
    repeat (30) @(posedge i_mclk);
    check({o_rd_valid, rd_q.size() == 9, acc_q.size() == 1, sel}, 6'h3f);
    stall <= 1'b0;
    wait_idle();
    check({sel, o_ext_data_oe, o_ext_address}, {3'h7, 1'b0, last_a});
    results();
  end

  initial begin
    #300_000;
    num_errors++;
    results();
  end
endmodule
